//--- irq_regs_pkg.sv
// Register map, field positions and reset values of the interrupt register set
package irq_regs_pkg;

  localparam logic [3:0] ADDR_EDGE_SEL = 4'h0;
  localparam logic [3:0] ADDR_CTRL0    = 4'h1;
  localparam logic [3:0] ADDR_CTRL1    = 4'h2;
  localparam logic [3:0] ADDR_CTRL2    = 4'h3;
  localparam logic [3:0] ADDR_CTRL3    = 4'h4;
  localparam logic [3:0] ADDR_MFUNC0   = 4'h5;
  localparam logic [3:0] ADDR_MFUNC1   = 4'h6;
  localparam logic [3:0] ADDR_MFUNC2   = 4'h7;
  localparam logic [3:0] ADDR_STATUS   = 4'h8;
  localparam logic [3:0] ADDR_MASK     = 4'h9;

  // Variant selection
  localparam logic [1:0] VAR_SMALL   = 2'h0;
  localparam logic [1:0] VAR_MEDIUM  = 2'h1;
  localparam logic [1:0] VAR_LARGE   = 2'h2;
  localparam logic [1:0] VAR_LARGEST = 2'h3;

  // Edge selector codes
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Bit positions
  localparam int BIT_GLOBAL_EN = 0;
  localparam int BIT_EXT_EN    = 1;
  localparam int BIT_EXT_FLAG  = 4;
  localparam int BIT_FLAG_HI   = 7;
  localparam int BIT_FLAG_LO   = 5;
  localparam int BIT_EN_HI     = 3;
  localparam int BIT_EN_LO     = 1;

  // Implemented-bit masks
  localparam logic [7:0] MASK_EDGE_SEL = 8'h03;
  localparam logic [7:0] MASK_CTRL0    = 8'h7F;
  localparam logic [7:0] MASK_FULL     = 8'hFF;
  localparam logic [7:0] MASK_CTRL2_S  = 8'h11;
  localparam logic [7:0] MASK_CTRL2_M  = 8'h77;
  localparam logic [7:0] MASK_MF1_M    = 8'h33;
  localparam logic [7:0] MASK_NONE     = 8'h00;
  localparam logic [7:0] MASK_STATUS   = 8'h07;

  localparam logic [7:0] RESET_REG = 8'h00;

endpackage

//--- irq_regs.sv
// Interrupt request and enable register set with edge-detecting external pin
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/10ps
// Function
// (R1) Edge selector: none, rise, fall, both
// (R2) Edge selector bits 7..2 read zero
// (R3) Control0 bit0 is global enable
// (R4) Control0 pin flag bit4, enable bit1
// (R5) Control0 touch1/0 flags 6/5, enables 3/2
// (R6) Control0 bit7 reads zero
// (R7) Single timer: control1 flag 7, enable 3
// (R8) Largest variant: same bits serve timer zero
// (R9) Control1 group0 flag 6, enable 2
// (R10) Control1 eeprom flag 5, enable 1
// (R11) Control1 serial flag 4, enable 0
// (R12) Control2 time base flag 4, enable 0
// (R13) Smallest variant control2 unused bits read zero
// (R14) Larger variants control2 touch3/2, group1 bits; medium variant implements touch2 and group1, not touch3
// (R15) Largest variant control3 touch5/4, group2, timer1
// (R16) Multi-function counter flags 7/5, enables 3/1
// (R17) Flags set always; request needs both enables
// (R18) Flags writable; hardware set beats clear
// (R19) Synchronise pin, selected edge sets flag
module irq_regs
  import irq_regs_pkg::*;
#(
  parameter logic [1:0] VARIANT = VAR_LARGEST
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // External pin
  input  wire logic       ext_pin,
  // Source events, one-cycle pulses
  input  wire logic [5:0] touch_evt,
  input  wire logic [5:0] touch_counter_evt,
  input  wire logic       timer_zero_evt,
  input  wire logic       timer_one_evt,
  input  wire logic       eeprom_evt,
  input  wire logic       serial_module_evt,
  input  wire logic       time_base_evt,
  // Interrupt requests to the core
  output logic      [7:0] src_request,
  output logic            core_irq,
  output logic            irq
);

  logic [7:0] edge_sel_q;
  logic [7:0] ctrl_q [0:3];
  logic [7:0] mfunc_q [0:2];
  logic [7:0] ctrl_set [0:3];
  logic [7:0] mfunc_set [0:2];
  logic [7:0] ctrl_msk [0:3];
  logic [7:0] mfunc_msk [0:2];
  logic [2:0] status_q;
  logic [2:0] mask_q;
  logic [2:0] status_evt;
  logic       pin_meta_q;
  logic       pin_sync_q;
  logic       pin_last_q;
  logic       pin_edge;
  logic [2:0] group_flag;
  logic       read_status;

  // Implemented bits per variant
  always_comb begin
    ctrl_msk[0]  = MASK_CTRL0; // [R6]
    ctrl_msk[1]  = MASK_FULL; // [R7] [R8]
    ctrl_msk[2]  = (VARIANT == VAR_SMALL) ? MASK_CTRL2_S : // [R13]
                   (VARIANT == VAR_MEDIUM) ? MASK_CTRL2_M : MASK_FULL; // [R14]
    ctrl_msk[3]  = (VARIANT == VAR_LARGEST) ? MASK_FULL : MASK_NONE; // [R15]
    mfunc_msk[0] = MASK_FULL;
    mfunc_msk[1] = (VARIANT == VAR_SMALL) ? MASK_NONE :
                   (VARIANT == VAR_MEDIUM) ? MASK_MF1_M : MASK_FULL;
    mfunc_msk[2] = (VARIANT == VAR_LARGEST) ? MASK_FULL : MASK_NONE;
  end

  // Pin synchroniser and edge detect
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_last_q <= 1'b0;
    end else begin
      pin_meta_q <= ext_pin; // [R19]
      pin_sync_q <= pin_meta_q;
      pin_last_q <= pin_sync_q;
    end
  end

  always_comb begin
    unique case (edge_sel_q[1:0]) // [R1]
      EDGE_NONE: pin_edge = 1'b0;
      EDGE_RISE: pin_edge = pin_sync_q & ~pin_last_q;
      EDGE_FALL: pin_edge = ~pin_sync_q & pin_last_q;
      EDGE_BOTH: pin_edge = pin_sync_q ^ pin_last_q; // [R19]
    endcase
  end

  // Group summaries of counter sub-sources
  always_comb begin
    for (int g = 0; g < 3; g++) begin
      group_flag[g] = (mfunc_q[g][BIT_FLAG_HI] & mfunc_q[g][BIT_EN_HI]) |
                      (mfunc_q[g][BIT_FLAG_LO] & mfunc_q[g][BIT_EN_LO]); // [R9]
    end
  end

  // Hardware set vectors; only the group bits depend on counter enables
  always_comb begin
    ctrl_set[0] = {1'b0, touch_evt[1], touch_evt[0], pin_edge, 4'h0}; // [R4] [R5] [R17]
    ctrl_set[1] = {timer_zero_evt, group_flag[0], eeprom_evt, serial_module_evt, 4'h0}; // [R10] [R11]
    ctrl_set[2] = {touch_evt[3], touch_evt[2], group_flag[1], time_base_evt, 4'h0}; // [R12] [R14]
    ctrl_set[3] = {touch_evt[5], touch_evt[4], group_flag[2], timer_one_evt, 4'h0}; // [R15]
    for (int g = 0; g < 3; g++) begin
      mfunc_set[g] = {touch_counter_evt[2 * g + 1], 1'b0, touch_counter_evt[2 * g], 5'h00}; // [R16]
    end
  end

  // Edge selector register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      edge_sel_q <= RESET_REG;
    end else if (wr && addr == ADDR_EDGE_SEL) begin
      edge_sel_q <= wdata & MASK_EDGE_SEL; // [R2]
    end
  end

  // Primary control registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int r = 0; r < 4; r++) begin
        ctrl_q[r] <= RESET_REG;
      end
    end else begin
      for (int r = 0; r < 4; r++) begin
        if (wr && addr == ADDR_CTRL0 + 4'(r)) begin
          ctrl_q[r] <= (wdata | ctrl_set[r]) & ctrl_msk[r]; // [R18]
        end else begin
          ctrl_q[r] <= (ctrl_q[r] | ctrl_set[r]) & ctrl_msk[r];
        end
      end
    end
  end

  // Multi-function registers; reserved bits stored as written where the variant mask keeps them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int r = 0; r < 3; r++) begin
        mfunc_q[r] <= RESET_REG;
      end
    end else begin
      for (int r = 0; r < 3; r++) begin
        if (wr && addr == ADDR_MFUNC0 + 4'(r)) begin
          mfunc_q[r] <= (wdata | mfunc_set[r]) & mfunc_msk[r]; // [R16] [R18]
        end else begin
          mfunc_q[r] <= (mfunc_q[r] | mfunc_set[r]) & mfunc_msk[r];
        end
      end
    end
  end

  // Request routing to the core
  always_comb begin
    src_request[0] = ctrl_q[0][BIT_EXT_FLAG] & ctrl_q[0][BIT_EXT_EN]; // [R4]
    src_request[1] = ctrl_q[0][BIT_FLAG_LO] & ctrl_q[0][2];
    src_request[2] = ctrl_q[0][6] & ctrl_q[0][BIT_EN_HI];
    src_request[3] = |(ctrl_q[1][7:4] & ctrl_q[1][3:0]);
    src_request[4] = |(ctrl_q[2][7:4] & ctrl_q[2][3:0]);
    src_request[5] = |(ctrl_q[3][7:4] & ctrl_q[3][3:0]);
    src_request[6] = ctrl_q[0][BIT_GLOBAL_EN]; // [R3]
    src_request[7] = 1'b0;
  end

  assign core_irq = ctrl_q[0][BIT_GLOBAL_EN] & (|src_request[5:0]); // [R3] [R17]

  // Sticky status: pin edge, core request level, group summary
  assign status_evt  = {|group_flag, core_irq, pin_edge};
  assign read_status = rd && addr == ADDR_STATUS;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_q <= 3'h0;
    end else if (read_status) begin
      status_q <= status_evt;
    end else begin
      status_q <= status_q | status_evt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_q <= 3'h0;
    end else if (wr && addr == ADDR_MASK) begin
      mask_q <= wdata[2:0];
    end
  end

  assign irq = |(status_q & mask_q);

  // Read data one cycle after strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= RESET_REG;
    end else if (rd) begin
      unique case (addr)
        ADDR_EDGE_SEL: rdata <= edge_sel_q & MASK_EDGE_SEL; // [R2]
        ADDR_CTRL0:    rdata <= ctrl_q[0];
        ADDR_CTRL1:    rdata <= ctrl_q[1];
        ADDR_CTRL2:    rdata <= ctrl_q[2]; // [R13]
        ADDR_CTRL3:    rdata <= ctrl_q[3];
        ADDR_MFUNC0:   rdata <= mfunc_q[0];
        ADDR_MFUNC1:   rdata <= mfunc_q[1];
        ADDR_MFUNC2:   rdata <= mfunc_q[2];
        ADDR_STATUS:   rdata <= {5'h00, status_q};
        ADDR_MASK:     rdata <= {5'h00, mask_q};
        default:       rdata <= RESET_REG;
      endcase
    end else begin
      rdata <= RESET_REG;
    end
  end

endmodule

//--- src_model.sv
// Peripheral event sources pulsing one set line per command
`timescale 1ns/10ps
module src_model (
  // Clock
  input  wire logic        clk,
  // Command
  input  wire logic        go,
  input  wire logic [4:0]  sel,
  // Set pulses
  output logic      [16:0] evt
);
  // Pulse ignores all enables
  always_ff @(posedge clk) begin
    evt <= go ? (17'h00001 << sel) : 17'h00000;
  end
endmodule

//--- irq_regs_checker.sv
// Concurrent checks on the register port and request outputs
`timescale 1ns/10ps
module irq_regs_checker
  import irq_regs_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Observed port
  input wire logic [3:0] addr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic [7:0] src_request,
  input wire logic       core_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  edge_pad_a: assert property (rd && addr == ADDR_EDGE_SEL |=> rdata[7:2] == 6'h00)
    else $error("edge selector upper bits not zero");
  ctrl0_top_a: assert property (rd && addr == ADDR_CTRL0 |=> !rdata[7])
    else $error("control0 bit7 not zero");
  global_bit_a: assert property (rd && addr == ADDR_CTRL0 |=> rdata[0] == $past(src_request[6]))
    else $error("global enable bit mismatch");
  pin_req_a: assert property (rd && addr == ADDR_CTRL0 |=> (rdata[4] && rdata[1]) == $past(src_request[0]))
    else $error("pin request mismatch");
  touch0_req_a: assert property (rd && addr == ADDR_CTRL0 |=> (rdata[5] && rdata[2]) == $past(src_request[1]))
    else $error("touch0 request mismatch");
  core_gate_a: assert property (core_irq == (src_request[6] && |src_request[5:0]))
    else $error("core request gating wrong");
  serial_req_a: assert property (rd && addr == ADDR_CTRL1 ##1 rdata[4] && rdata[0] |-> $past(src_request[3]))
    else $error("serial request missing");
  tbase_req_a: assert property (rd && addr == ADDR_CTRL2 ##1 rdata[4] && rdata[0] |-> $past(src_request[4]))
    else $error("time base request missing");
endmodule
bind irq_regs irq_regs_checker u_chk (.clk(clk), .rst_n(rst_n), .addr(addr), .rd(rd), .rdata(rdata),
  .src_request(src_request), .core_irq(core_irq));

//--- tb.sv
// Self-checking bench for the interrupt register set
`timescale 1ns/10ps
module tb
  import irq_regs_pkg::*;
;
  logic        clk, rst_n, wr, rd, ext_pin, go, core_irq, irq;
  logic [3:0]  addr;
  logic [4:0]  sel;
  logic [7:0]  wdata, rdata, src_request;
  logic [16:0] evt;
  int          n_fail, num_checks;
  // Register index and bit of each event line
  localparam logic [7:0] MAP [17] = '{8'h15, 8'h16, 8'h36, 8'h37, 8'h46, 8'h47, 8'h55, 8'h57, 8'h65,
    8'h67, 8'h75, 8'h77, 8'h27, 8'h44, 8'h25, 8'h24, 8'h34};
  irq_regs #(.VARIANT(VAR_LARGEST)) u_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .ext_pin(ext_pin), .touch_evt(evt[5:0]),
    .touch_counter_evt(evt[11:6]), .timer_zero_evt(evt[12]), .timer_one_evt(evt[13]),
    .eeprom_evt(evt[14]), .serial_module_evt(evt[15]), .time_base_evt(evt[16]),
    .src_request(src_request), .core_irq(core_irq), .irq(irq));
  src_model u_src (.clk(clk), .go(go), .sel(sel), .evt(evt));
  task give_verdict;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) {addr, wdata, wr} <= {a, d, 1'h1};
    @(posedge clk) wr <= 1'h0;
  endtask
  task rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk) {addr, rd} <= {a, 1'h1};
    @(posedge clk) rd <= 1'h0;
    #1 chk("rdata", e, rdata);
  endtask
  task pulse(input logic [4:0] s);
    @(posedge clk) {sel, go} <= {s, 1'h1};
    @(posedge clk) go <= 1'h0;
  endtask
  task t_edge;
    for (int i = 0; i < 4; i++) begin
      wr_reg(ADDR_EDGE_SEL, {6'h3F, i[1:0]});
      rd_chk(ADDR_EDGE_SEL, {6'h00, i[1:0]});
      @(posedge clk) ext_pin <= 1'h1;
      repeat (5) @(posedge clk);
      rd_chk(ADDR_CTRL0, {3'h0, i[0], 4'h0});
      wr_reg(ADDR_CTRL0, 8'h00);
      @(posedge clk) ext_pin <= 1'h0;
      repeat (5) @(posedge clk);
      rd_chk(ADDR_CTRL0, {3'h0, i[1], 4'h0});
      wr_reg(ADDR_CTRL0, 8'h00);
    end
  endtask
  task t_flags;
    for (int i = 0; i < 17; i++) begin
      pulse(i[4:0]);
      rd_chk(MAP[i][7:4], 8'h01 << MAP[i][2:0]);
      wr_reg(MAP[i][7:4], 8'h00);
      rd_chk(MAP[i][7:4], 8'h00);
    end
    @(posedge clk) {sel, go} <= {5'h10, 1'h1};
    @(posedge clk) {go, addr, wdata, wr} <= {1'h0, ADDR_CTRL2, 8'h00, 1'h1};
    @(posedge clk) wr <= 1'h0;
    rd_chk(ADDR_CTRL2, 8'h10);
    wr_reg(ADDR_CTRL3, 8'hFF);
    rd_chk(ADDR_CTRL3, 8'hFF);
    wr_reg(ADDR_CTRL0, 8'hFF);
    rd_chk(ADDR_CTRL0, 8'h7F);
    wr_reg(ADDR_CTRL0, 8'h00);
    wr_reg(ADDR_CTRL2, 8'h00);
    wr_reg(ADDR_CTRL3, 8'h00);
  endtask
  task t_irq;
    wr_reg(ADDR_EDGE_SEL, 8'h01);
    wr_reg(ADDR_MASK, 8'h01);
    wr_reg(ADDR_CTRL0, 8'h03);
    @(posedge clk) ext_pin <= 1'h1;
    repeat (5) @(posedge clk);
    #1;
    chk("irq", 8'h01, {7'h00, irq});
    chk("core_irq", 8'h01, {7'h00, core_irq});
    rd_chk(ADDR_STATUS, 8'h03);
    chk("irq", 8'h00, {7'h00, irq});
    wr_reg(ADDR_MASK, 8'h00);
    wr_reg(ADDR_CTRL0, 8'h12);
    #1;
    chk("core_irq", 8'h00, {7'h00, core_irq});
    chk("src_request", 8'h01, src_request);
    wr_reg(ADDR_CTRL0, 8'h00);
    @(posedge clk) ext_pin <= 1'h0;
    wr_reg(ADDR_MFUNC0, 8'h02);
    pulse(5'h06);
    repeat (2) @(posedge clk);
    rd_chk(ADDR_CTRL1, 8'h40);
    rd_chk(ADDR_MFUNC0, 8'h22);
    wr_reg(4'hA, 8'hFF);
    rd_chk(4'hA, 8'h00);
  endtask
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    n_fail++;
    give_verdict();
  end
  initial begin
    {rst_n, wr, rd, ext_pin, go, addr, sel, wdata} = '0;
    n_fail = 0;
    num_checks = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    for (int i = 0; i < 10; i++) rd_chk(i[3:0], RESET_REG);
    t_edge();
    t_flags();
    t_irq();
    give_verdict();
  end
endmodule
